// File: design/prai_regs.svh
// constants for the pll reset and alarm pin block
`ifndef PRAI_REGS_SVH
`define PRAI_REGS_SVH
`define PRAI_NUM_PLL 4
`define PRAI_ALARM_EN_RST 4'h0
`define PRAI_ALARM_POL_RST 4'hf
`define PRAI_BAD_POL_RST 4'hf
`define PRAI_LOL_EN_RST 4'h0
`define PRAI_LOL_POL_RST 4'hf
`endif

// File: design/prai_pkg.sv
// types for the pll reset and alarm pin block
package prai_pkg;
    // per-pll pin configuration
    typedef struct packed {
        logic alarm_out_enable;
        logic alarm_out_polarity;
        logic bad_input_polarity;
        logic lock_loss_pin_enable;
        logic lock_loss_polarity;
    } prai_cfg_t;
    // per-pll pin drive, three signals per pin minus input
    typedef struct packed {
        logic value;
        logic oe;
    } prai_pin_t;
endpackage

// File: design/prai_top.sv
// reset, alarm and lock-loss pin logic for four plls
`timescale 1ns/100ps
`default_nettype none
`include "prai_regs.svh"
module prai_top #(
    parameter int NPLL = `PRAI_NUM_PLL
) (
    // clock and resets
    input wire logic clk,
    input wire logic rstn,
    input wire logic ext_reset_n,
    // configuration write, one strobe for all field groups
    input wire logic cfg_we,
    input wire logic [NPLL-1:0] cfg_alarm_en,
    input wire logic [NPLL-1:0] cfg_alarm_pol,
    input wire logic [NPLL-1:0] cfg_bad_pol,
    input wire logic [NPLL-1:0] cfg_lol_en,
    input wire logic [NPLL-1:0] cfg_lol_pol,
    // clock output enable request from datapath
    input wire logic [NPLL-1:0] clk_out_enable_req,
    // monitor status from each pll
    input wire logic [NPLL-1:0] signal_loss_alarm,
    input wire logic [NPLL-1:0] freq_offset_alarm,
    input wire logic [NPLL-1:0] pll_locked,
    // indicator pins and clock output enables
    output logic [NPLL-1:0] alarm_pin_o,
    output logic [NPLL-1:0] alarm_pin_oe,
    output logic [NPLL-1:0] lock_loss_out_o,
    output logic [NPLL-1:0] lock_loss_out_oe,
    output logic [NPLL-1:0] clk_out_oe,
    // status readback
    output logic [NPLL-1:0] lock_loss_status_bit,
    output logic [NPLL-1:0] alarm_status_bit,
    output logic configured
);

    prai_pkg::prai_cfg_t cfg_reg [NPLL];
    logic in_reset;
    logic [NPLL-1:0] alarm_reg;
    logic [NPLL-1:0] unlock_reg;

    // one pll's reset value out of a per-pll default word; words repeat every four plls
    function automatic logic def_bit(input logic [3:0] word, input int idx);
        return word[idx[1:0]];
    endfunction

    // both resets share one meaning: external pin and system reset
    assign in_reset = !rstn || !ext_reset_n;

    // configuration registers, defaults restored on any reset
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NPLL; i++)
        begin
            if (in_reset)
            begin
                cfg_reg[i].alarm_out_enable <= def_bit(`PRAI_ALARM_EN_RST, i);
                cfg_reg[i].alarm_out_polarity <= def_bit(`PRAI_ALARM_POL_RST, i);
                cfg_reg[i].bad_input_polarity <= def_bit(`PRAI_BAD_POL_RST, i);
                cfg_reg[i].lock_loss_pin_enable <= def_bit(`PRAI_LOL_EN_RST, i);
                cfg_reg[i].lock_loss_polarity <= def_bit(`PRAI_LOL_POL_RST, i);
            end
            else if (cfg_we)
            begin
                cfg_reg[i].alarm_out_enable <= cfg_alarm_en[i];
                cfg_reg[i].alarm_out_polarity <= cfg_alarm_pol[i];
                cfg_reg[i].bad_input_polarity <= cfg_bad_pol[i];
                cfg_reg[i].lock_loss_pin_enable <= cfg_lol_en[i];
                cfg_reg[i].lock_loss_polarity <= cfg_lol_pol[i];
            end
        end
    end

    // set once software has programmed the part; gates clock outputs
    always_ff @(posedge clk)
    begin
        if (in_reset)
            configured <= 1'b0;
        else if (cfg_we)
            configured <= 1'b1;
    end

    // registered monitor status
    always_ff @(posedge clk)
    begin
        if (in_reset)
        begin
            alarm_reg <= '0;
            unlock_reg <= '0;
        end
        else
        begin
            alarm_reg <= signal_loss_alarm | freq_offset_alarm;
            unlock_reg <= ~pll_locked;
        end
    end

    // pin drive, one slice per pll
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NPLL; i++)
        begin
            if (in_reset)
            begin
                alarm_pin_o[i] <= 1'b0;
                alarm_pin_oe[i] <= 1'b0;
                lock_loss_out_o[i] <= 1'b0;
                lock_loss_out_oe[i] <= 1'b0;
                clk_out_oe[i] <= 1'b0;
                lock_loss_status_bit[i] <= 1'b0;
                alarm_status_bit[i] <= 1'b0;
            end
            else
            begin
                // polarity bit high means active-high pin; both bits combine
                alarm_pin_o[i] <= alarm_reg[i] ^ ~cfg_reg[i].alarm_out_polarity
                                  ^ ~cfg_reg[i].bad_input_polarity;
                alarm_pin_oe[i] <= cfg_reg[i].alarm_out_enable;
                lock_loss_out_o[i] <= unlock_reg[i] ^ ~cfg_reg[i].lock_loss_polarity;
                lock_loss_out_oe[i] <= cfg_reg[i].lock_loss_pin_enable;
                clk_out_oe[i] <= configured && clk_out_enable_req[i];
                lock_loss_status_bit[i] <= unlock_reg[i];
                alarm_status_bit[i] <= alarm_reg[i];
            end
        end
    end

    // clock outputs stay off during reset
    property p_clk_off;
        @(posedge clk) !ext_reset_n |=> clk_out_oe == '0;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock output on in reset");

    property p_cfg_default;
        @(posedge clk) !ext_reset_n |=> (alarm_pin_oe == '0) ##0 (lock_loss_out_oe == '0) [*1];
    endproperty
    a_cfg_default: assert property (p_cfg_default) else $error("pins enabled after reset");

    property p_alarm_oe;
        @(posedge clk) disable iff (in_reset)
            ##1 !in_reset ##0 (cfg_reg[0].alarm_out_enable == 1'b0) |=> !alarm_pin_oe[0];
    endproperty
    a_alarm_oe: assert property (p_alarm_oe) else $error("alarm pin driven while disabled");

    property p_lol_oe;
        @(posedge clk) disable iff (in_reset)
            !cfg_reg[1].lock_loss_pin_enable |=> !lock_loss_out_oe[1];
    endproperty
    a_lol_oe: assert property (p_lol_oe) else $error("lock-loss pin driven while disabled");

    property p_alarm_level;
        @(posedge clk) disable iff (in_reset)
            signal_loss_alarm[0] ##1 (cfg_reg[0].alarm_out_polarity && cfg_reg[0].bad_input_polarity)
            |=> alarm_pin_o[0];
    endproperty
    a_alarm_level: assert property (p_alarm_level) else $error("alarm pin not asserted");

    property p_status;
        @(posedge clk) disable iff (in_reset)
            (!pll_locked[2] [*3]) |=> lock_loss_status_bit[2];
    endproperty
    a_status: assert property (p_status) else $error("status bit misses unlock");

    property p_lol_level;
        @(posedge clk) disable iff (in_reset)
            (pll_locked[3] [*3]) ##0 (cfg_reg[3].lock_loss_polarity [*2]) |=> !lock_loss_out_o[3];
    endproperty
    a_lol_level: assert property (p_lol_level) else $error("lock-loss pin wrong when locked");

    property p_lol_invert;
        @(posedge clk) disable iff (in_reset)
            (pll_locked[3] [*3]) ##0 (!cfg_reg[3].lock_loss_polarity [*2]) |=> lock_loss_out_o[3];
    endproperty
    a_lol_invert: assert property (p_lol_invert) else $error("lock-loss polarity ignored");

    property p_unconfigured;
        @(posedge clk) disable iff (in_reset)
            !configured |=> clk_out_oe == '0;
    endproperty
    a_unconfigured: assert property (p_unconfigured) else $error("clock before configuration");

    // any reset clears the status bits and the configured flag
    property p_rst_state;
        @(posedge clk) in_reset |=> !configured && alarm_status_bit == '0 && lock_loss_status_bit == '0;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("state not cleared by reset");

    // defaults come back even when a write meets the reset edge
    property p_cfg_reset;
        @(posedge clk) in_reset |=> cfg_reg[2].alarm_out_polarity == def_bit(`PRAI_ALARM_POL_RST, 2)
            && cfg_reg[2].lock_loss_pin_enable == def_bit(`PRAI_LOL_EN_RST, 2);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("configuration not at default after reset");

    // an enabled alarm pin is driven one edge later
    property p_alarm_drive;
        @(posedge clk) disable iff (in_reset)
            cfg_reg[2].alarm_out_enable |=> alarm_pin_oe[2];
    endproperty
    a_alarm_drive: assert property (p_alarm_drive) else $error("enabled alarm pin released");

    // low alarm polarity on its own flips the pin
    property p_alarm_invert;
        @(posedge clk) disable iff (in_reset)
            signal_loss_alarm[3] ##1 (!cfg_reg[3].alarm_out_polarity && cfg_reg[3].bad_input_polarity)
            |=> !alarm_pin_o[3];
    endproperty
    a_alarm_invert: assert property (p_alarm_invert) else $error("alarm polarity ignored");

    // status follows the monitors two edges later, in both directions
    property p_alarm_status;
        @(posedge clk) disable iff (in_reset)
            (signal_loss_alarm[1] || freq_offset_alarm[1]) |=> ##1 alarm_status_bit[1];
    endproperty
    a_alarm_status: assert property (p_alarm_status) else $error("alarm status misses alarm");

    property p_alarm_clear;
        @(posedge clk) disable iff (in_reset)
            (!signal_loss_alarm[1] && !freq_offset_alarm[1]) |=> ##1 !alarm_status_bit[1];
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) else $error("alarm status set with clean input");

    // an enabled lock-loss pin is driven one edge later
    property p_lol_drive;
        @(posedge clk) disable iff (in_reset)
            cfg_reg[0].lock_loss_pin_enable |=> lock_loss_out_oe[0];
    endproperty
    a_lol_drive: assert property (p_lol_drive) else $error("enabled lock-loss pin released");

endmodule
`default_nettype wire

// File: testbench/prai_host.sv
// host model: drives the external reset and resolves one group of indicator pins
`timescale 1ns/100ps
`default_nettype none
module prai_host (
    // clock and reset request
    input wire logic clk,
    input wire logic rst_req,
    output logic ext_reset_n,
    // indicator pins
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_lvl
);
    logic [3:0] last_reg = 4'h0;
    // undriven pins toggle, so a wrongly released pin never passes by luck
    always_ff @(posedge clk)
    begin
        last_reg <= pin_lvl;
    end
    assign pin_lvl = (pin_o & pin_oe) | (~last_reg & ~pin_oe);
    // reset changes off the sampling edge
    always_ff @(negedge clk)
    begin
        ext_reset_n <= ~rst_req;
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the reset, alarm and lock-loss pin block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rstn, rst_req, ext_reset_n, cfg_we, configured;
    logic [3:0] aen, apol, bpol, len, lpol, req, sl, fo, lk, a_o, a_oe, l_o, l_oe, c_oe, l_st, a_st, a_lvl, l_lvl;
    logic [15:0] rnd;
    int err_count = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    prai_top DUT (.clk(clk), .rstn(rstn), .ext_reset_n(ext_reset_n), .cfg_we(cfg_we), .cfg_alarm_en(aen),
        .cfg_alarm_pol(apol), .cfg_bad_pol(bpol), .cfg_lol_en(len), .cfg_lol_pol(lpol), .clk_out_enable_req(req),
        .signal_loss_alarm(sl), .freq_offset_alarm(fo), .pll_locked(lk), .alarm_pin_o(a_o), .alarm_pin_oe(a_oe),
        .lock_loss_out_o(l_o), .lock_loss_out_oe(l_oe), .clk_out_oe(c_oe), .lock_loss_status_bit(l_st),
        .alarm_status_bit(a_st), .configured(configured));
    prai_host host_a (.clk(clk), .rst_req(rst_req), .ext_reset_n(ext_reset_n), .pin_o(a_o), .pin_oe(a_oe),
        .pin_lvl(a_lvl));
    prai_host host_l (.clk(clk), .rst_req(1'b0), .ext_reset_n(), .pin_o(l_o), .pin_oe(l_oe), .pin_lvl(l_lvl));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected pin levels: a set polarity bit keeps the raw indication, a clear one inverts it
    function automatic logic [3:0] exp_alarm(input logic [3:0] s, input logic [3:0] f, input logic [3:0] ap,
        input logic [3:0] bp);
        return (s | f) ^ ~ap ^ ~bp;
    endfunction
    function automatic logic [3:0] exp_lol(input logic [3:0] locked, input logic [3:0] lp);
        return ~locked ^ ~lp;
    endfunction
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // reset leaves pins released, clocks off and defaults loaded
    task automatic check_idle();
        check(a_oe, 4'h0);
        check(l_oe, 4'h0);
        check(c_oe, 4'h0);
        check({3'h0, configured}, 4'h0);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        rnd = 16'h0059;
        {rstn, rst_req, cfg_we, aen, apol, bpol, len, lpol, req, sl, fo, lk} = '0;
        // clock request up from the start, so an unconfigured part must still hold its outputs off
        req = 4'hf;
        repeat (12) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        repeat (3) @(negedge clk);
        check_idle();
        check(c_oe, 4'h0);
        for (int i = 0; i < 40; i++)
        begin
            rnd = lfsr(rnd);
            {aen, apol, bpol, len} = rnd;
            rnd = lfsr(rnd);
            {lpol, req, sl, fo} = rnd;
            rnd = lfsr(rnd);
            lk = rnd[3:0];
            if (i == 0) {aen, len} = 8'hff;
            if (i == 20)
            begin
                // one cycle of host reset on the write's own edge: the write must be refused
                {aen, len, req} = 12'hfff;
                @(posedge clk) rst_req = 1'b1;
                @(negedge clk) cfg_we = 1'b1;
                @(posedge clk) rst_req = 1'b0;
            end
            else
                cfg_we = 1'b1;
            @(negedge clk) cfg_we = 1'b0;
            if (i == 20) check_idle();
            repeat (3) @(negedge clk);
            if (i == 20)
            begin
                check_idle();
                check(a_o, exp_alarm(sl, fo, 4'hf, 4'hf));
                check(l_o, exp_lol(lk, 4'hf));
            end
            else
            begin
                check(a_oe, aen);
                check(a_o, exp_alarm(sl, fo, apol, bpol));
                check(a_lvl & aen, exp_alarm(sl, fo, apol, bpol) & aen);
                check(a_st, sl | fo);
                check(l_oe, len);
                check(l_o, exp_lol(lk, lpol));
                check((l_lvl ^ ~lpol) & len, ~lk & len);
                check(l_st, ~lk);
                check(c_oe, req);
                check({3'h0, configured}, 4'h1);
            end
            $display("test %0d done", i);
        end
        complete_run();
    end
endmodule
`default_nettype wire
